// file: srac_pkg.sv
// Package with register map, field positions and constants of the SMBus range and control block.
package srac_pkg;

  // ==========================================
  // Register indices and byte addresses
  // ==========================================
  localparam int unsigned SRAC_ADDR_W = 8;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_IDX_RANGE_UPPER = 8'h07;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_IDX_SMB_CTRL = 8'h08;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_ADDR_RANGE_UPPER = 8'h1C;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_ADDR_SMB_CTRL = 8'h20;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_ADDR_PRIMARY = 8'h40;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_ADDR_SECOND = 8'h44;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_ADDR_LOW_TIMEOUT = 8'h48;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_ADDR_OWN_CTRL = 8'h4C;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_ADDR_IRQ_STATUS = 8'h50;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_ADDR_IRQ_MASK = 8'h54;
  localparam logic [SRAC_ADDR_W-1:0] SRAC_ADDR_MATCH_STATUS = 8'h58;

  // ==========================================
  // Control and status field positions
  // ==========================================
  localparam int unsigned SMB_FAST_ACK = 7;
  localparam int unsigned SMB_ALERT_EN = 6;
  localparam int unsigned SMB_SECOND_EN = 5;
  localparam int unsigned SMB_TCK_SEL = 4;
  localparam int unsigned SMB_SCL_LOW_TIMEOUT_FLAG = 3;
  localparam int unsigned SMB_IDLE_TF = 2;
  localparam int unsigned SMB_CHDL_TF = 1;
  localparam int unsigned SMB_CHDL_IE = 0;
  localparam logic [7:0] SMB_RESET = 8'h00;
  localparam logic [7:0] SMB_SW_MASK = 8'hF1;

  localparam int unsigned OWN_TRANSMIT_ACK_VALUE = 0;
  localparam int unsigned OWN_RANGE_MODE = 1;

  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_SCL_LOW_TIMEOUT_FLAG = 0;
  localparam int unsigned IRQ_CHDL = 1;
  localparam int unsigned IRQ_IDLE = 2;
  localparam int unsigned IRQ_MATCH = 3;
  localparam int unsigned IRQ_ACK_REQ = 4;

  // ==========================================
  // Address matching and timing
  // ==========================================
  localparam logic [6:0] SRAC_ALERT_RESPONSE_ADDR = 7'h0C;
  localparam logic [6:0] SRAC_ADDR_ZERO = 7'h00;
  localparam int unsigned SRAC_PRESCALE_DIV = 64;
  localparam int unsigned SRAC_PRESCALE_W = 6;
  localparam logic [SRAC_PRESCALE_W-1:0] SRAC_PRESCALE_LAST = 6'(SRAC_PRESCALE_DIV - 1);
  localparam int unsigned SRAC_HIGH_SHIFT = 9;
  localparam int unsigned SRAC_TO_W = 16;
  localparam int unsigned SRAC_NUM_TO = 3;
  localparam int unsigned TO_SCL_LOW = 0;
  localparam int unsigned TO_BUS_IDLE = 1;
  localparam int unsigned TO_CHDL = 2;

  localparam logic [1:0] AXI_RESP_OKAY = 2'b00;
  localparam logic [1:0] AXI_RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    SRAC_ACK_IDLE = 2'b00,
    SRAC_ACK_WAIT_SW = 2'b01,
    SRAC_ACK_SEND = 2'b11
  } srac_ack_state_t;

endpackage

// file: srac_timeout_counter.sv
// Saturating tick counter that flags a line condition lasting beyond a limit.
`timescale 1ns/1ps
module srac_timeout_counter
  import srac_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic cond,
  input wire logic enable,
  input wire logic [SRAC_TO_W-1:0] limit,
  output logic expired
);

  logic [SRAC_TO_W-1:0] count;
  wire at_max = &count;
  wire over_limit = count > limit;

  // ==========================================
  // Counter
  // ==========================================
  // The count restarts whenever the condition breaks, so only an unbroken stretch is measured.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (!cond || !enable) begin
      count <= '0;
    end else if (tick && !at_max) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expired <= 1'b0;
    end else begin
      expired <= enable && cond && over_limit;
    end
  end

endmodule // srac_timeout_counter

// file: srac_range_smbus.sv
// SMBus address matching, acknowledge control and timeout flags behind an AXI4-Lite slave.
`timescale 1ns/1ps

// Notes on behaviour
// - Range register holds a seven-bit slave address in bits seven to one.
// - A nonzero range register value enables it for address matching.
// - In range mode the range register is the upper address bound.
// - Range register bit zero reads zero and ignores writes.
// - Bus idle flag sets when both lines stay high beyond the high timeout.
// - Without fast acknowledge, the stored acknowledge value answers the next received byte.
// - With fast acknowledge, software writes zero for ACK, one for NACK per byte.
// - Alert enable turns alert response address matching on or off.
// - Second address enable turns matching of the second address on or off.
// - Timeout clock select: zero counts at clock over 64, one at full clock.
// - Idle flag is read-only, uses low timeout value over 512, clears itself.
// - Low timeout flag clears by writing one; zero low timeout disables detection.
module srac_range_smbus
  import srac_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SRAC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SRAC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [6:0] rx_address,
  input wire logic rx_address_valid,
  input wire logic rx_byte_done,
  output logic address_match,
  output logic [3:0] match_kind,
  output logic ack_valid,
  output logic ack_nack,
  output logic irq
);

  // ==========================================
  // Register state
  // ==========================================
  logic [6:0] range_slave_address;
  logic [7:0] smbus_control_status;
  logic [6:0] primary_address;
  logic [6:0] second_address;
  logic [SRAC_TO_W-1:0] low_timeout_value;
  logic transmit_ack_value;
  logic range_match_mode;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [6:0] last_match_address;

  logic aw_held;
  logic w_held;
  logic [SRAC_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ==========================================
  // AXI4-Lite handshakes
  // ==========================================
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // ==========================================
  // Write decode
  // ==========================================
  wire wr_lane0 = wr_fire && w_strb[0];
  wire wr_lane1 = wr_fire && w_strb[1];
  wire wr_range = wr_lane0 && (aw_addr == SRAC_ADDR_RANGE_UPPER);
  wire wr_smb = wr_lane0 && (aw_addr == SRAC_ADDR_SMB_CTRL);
  wire wr_primary = wr_lane0 && (aw_addr == SRAC_ADDR_PRIMARY);
  wire wr_second = wr_lane0 && (aw_addr == SRAC_ADDR_SECOND);
  wire wr_low_sel = aw_addr == SRAC_ADDR_LOW_TIMEOUT;
  wire wr_own = wr_lane0 && (aw_addr == SRAC_ADDR_OWN_CTRL);
  wire wr_irq_status = wr_lane0 && (aw_addr == SRAC_ADDR_IRQ_STATUS);
  wire wr_irq_mask = wr_lane0 && (aw_addr == SRAC_ADDR_IRQ_MASK);
  wire wr_mapped = (aw_addr == SRAC_ADDR_RANGE_UPPER) || (aw_addr == SRAC_ADDR_SMB_CTRL) ||
                   (aw_addr == SRAC_ADDR_PRIMARY) || (aw_addr == SRAC_ADDR_SECOND) || wr_low_sel ||
                   (aw_addr == SRAC_ADDR_OWN_CTRL) || (aw_addr == SRAC_ADDR_IRQ_STATUS) ||
                   (aw_addr == SRAC_ADDR_IRQ_MASK) || (aw_addr == SRAC_ADDR_MATCH_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? AXI_RESP_OKAY : AXI_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Bit zero of the written byte is dropped, so the range field only takes bits seven to one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_slave_address <= SRAC_ADDR_ZERO;
      primary_address <= SRAC_ADDR_ZERO;
      second_address <= SRAC_ADDR_ZERO;
      irq_mask <= '0;
    end else begin
      if (wr_range) begin
        range_slave_address <= w_data[7:1];
      end
      if (wr_primary) begin
        primary_address <= w_data[7:1];
      end
      if (wr_second) begin
        second_address <= w_data[7:1];
      end
      if (wr_irq_mask) begin
        irq_mask <= w_data[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_timeout_value <= '0;
      transmit_ack_value <= 1'b0;
      range_match_mode <= 1'b0;
    end else begin
      if (wr_low_sel && wr_lane0) begin
        low_timeout_value[7:0] <= w_data[7:0];
      end
      if (wr_low_sel && wr_lane1) begin
        low_timeout_value[15:8] <= w_data[15:8];
      end
      if (wr_own) begin
        transmit_ack_value <= w_data[OWN_TRANSMIT_ACK_VALUE];
        range_match_mode <= w_data[OWN_RANGE_MODE];
      end
    end
  end

  // ==========================================
  // Timeout prescaler and counters
  // ==========================================
  logic [SRAC_PRESCALE_W-1:0] prescale;
  wire fast_clock = smbus_control_status[SMB_TCK_SEL];
  wire to_tick = fast_clock || (prescale == SRAC_PRESCALE_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  wire low_enabled = |low_timeout_value;
  wire [SRAC_TO_W-1:0] high_limit = low_timeout_value >> SRAC_HIGH_SHIFT;
  wire [SRAC_NUM_TO-1:0] to_cond = {scl_in && !sda_in, scl_in && sda_in, !scl_in};
  wire [SRAC_TO_W-1:0] to_limit [SRAC_NUM_TO];
  logic [SRAC_NUM_TO-1:0] to_expired;
  logic [SRAC_NUM_TO-1:0] to_expired_d;

  assign to_limit[TO_SCL_LOW] = low_timeout_value;
  assign to_limit[TO_BUS_IDLE] = high_limit;
  assign to_limit[TO_CHDL] = high_limit;

  genvar gi;
  generate
    for (gi = 0; gi < SRAC_NUM_TO; gi++) begin : g_timeout
      srac_timeout_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(to_tick),
        .cond(to_cond[gi]),
        .enable(low_enabled),
        .limit(to_limit[gi]),
        .expired(to_expired[gi])
      );
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_expired_d <= '0;
    end else begin
      to_expired_d <= to_expired;
    end
  end

  wire [SRAC_NUM_TO-1:0] to_rise = to_expired & ~to_expired_d;

  // ==========================================
  // SMBus control and status register
  // ==========================================
  // Sticky flags take a new timeout even in the cycle software clears them.
  wire [7:0] smb_wdata = w_data[7:0];
  wire next_scl_low_timeout_flag = to_rise[TO_SCL_LOW] ||
                   (smbus_control_status[SMB_SCL_LOW_TIMEOUT_FLAG] && !(wr_smb && smb_wdata[SMB_SCL_LOW_TIMEOUT_FLAG]));
  wire next_chdl = to_rise[TO_CHDL] ||
                   (smbus_control_status[SMB_CHDL_TF] && !(wr_smb && smb_wdata[SMB_CHDL_TF]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smbus_control_status <= SMB_RESET;
    end else begin
      if (wr_smb) begin
        smbus_control_status[SMB_FAST_ACK] <= smb_wdata[SMB_FAST_ACK];
        smbus_control_status[SMB_ALERT_EN] <= smb_wdata[SMB_ALERT_EN];
        smbus_control_status[SMB_SECOND_EN] <= smb_wdata[SMB_SECOND_EN];
        smbus_control_status[SMB_TCK_SEL] <= smb_wdata[SMB_TCK_SEL];
        smbus_control_status[SMB_CHDL_IE] <= smb_wdata[SMB_CHDL_IE];
      end
      smbus_control_status[SMB_SCL_LOW_TIMEOUT_FLAG] <= next_scl_low_timeout_flag;
      smbus_control_status[SMB_IDLE_TF] <= to_expired[TO_BUS_IDLE];
      smbus_control_status[SMB_CHDL_TF] <= next_chdl;
    end
  end

  // ==========================================
  // Address matching
  // ==========================================
  wire range_active = range_slave_address != SRAC_ADDR_ZERO;
  wire in_range = (rx_address >= primary_address) && (rx_address <= range_slave_address);
  wire hit_primary = rx_address == primary_address;
  wire hit_range = range_active && (range_match_mode ? in_range : (rx_address == range_slave_address));
  wire hit_alert = smbus_control_status[SMB_ALERT_EN] && (rx_address == SRAC_ALERT_RESPONSE_ADDR);
  wire hit_second = smbus_control_status[SMB_SECOND_EN] && (rx_address == second_address);
  wire [3:0] hit_vector = {hit_second, hit_alert, hit_range, hit_primary};
  wire any_hit = |hit_vector;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      address_match <= 1'b0;
      match_kind <= '0;
      last_match_address <= SRAC_ADDR_ZERO;
    end else begin
      address_match <= rx_address_valid && any_hit;
      if (rx_address_valid && any_hit) begin
        match_kind <= hit_vector;
        last_match_address <= rx_address;
      end
    end
  end

  // ==========================================
  // Acknowledge control
  // ==========================================
  srac_ack_state_t ack_state;
  srac_ack_state_t next_ack_state;
  logic ack_value;
  logic next_ack_value;
  wire fast_ack = smbus_control_status[SMB_FAST_ACK];

  // Fast mode holds the bus decision until software writes its verdict for this byte.
  always_comb begin
    next_ack_state = ack_state;
    next_ack_value = ack_value;
    case (ack_state)
      SRAC_ACK_IDLE: begin
        if (rx_byte_done && fast_ack) begin
          next_ack_state = SRAC_ACK_WAIT_SW;
        end else if (rx_byte_done) begin
          next_ack_state = SRAC_ACK_SEND;
          next_ack_value = transmit_ack_value;
        end
      end
      SRAC_ACK_WAIT_SW: begin
        if (wr_own) begin
          next_ack_state = SRAC_ACK_SEND;
          next_ack_value = w_data[OWN_TRANSMIT_ACK_VALUE];
        end
      end
      SRAC_ACK_SEND: begin
        next_ack_state = SRAC_ACK_IDLE;
      end
      default: begin
        next_ack_state = SRAC_ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_state <= SRAC_ACK_IDLE;
      ack_value <= 1'b0;
    end else begin
      ack_state <= next_ack_state;
      ack_value <= next_ack_value;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_valid <= 1'b0;
      ack_nack <= 1'b0;
    end else begin
      ack_valid <= next_ack_state == SRAC_ACK_SEND;
      ack_nack <= next_ack_value;
    end
  end

  // ==========================================
  // Interrupts
  // ==========================================
  wire [IRQ_W-1:0] irq_event;
  assign irq_event[IRQ_SCL_LOW_TIMEOUT_FLAG] = to_rise[TO_SCL_LOW];
  assign irq_event[IRQ_CHDL] = to_rise[TO_CHDL];
  assign irq_event[IRQ_IDLE] = to_rise[TO_BUS_IDLE];
  assign irq_event[IRQ_MATCH] = rx_address_valid && any_hit;
  assign irq_event[IRQ_ACK_REQ] = (ack_state == SRAC_ACK_IDLE) && (next_ack_state == SRAC_ACK_WAIT_SW);

  wire [IRQ_W-1:0] irq_clear = wr_irq_status ? w_data[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= irq_event | (irq_status & ~irq_clear);
      irq <= |(irq_status & irq_mask) ||
             (smbus_control_status[SMB_CHDL_TF] && smbus_control_status[SMB_CHDL_IE]);
    end
  end

  // ==========================================
  // Read path
  // ==========================================
  wire [SRAC_ADDR_W-1:0] ra = s_axi_araddr;
  wire rd_mapped = (ra == SRAC_ADDR_RANGE_UPPER) || (ra == SRAC_ADDR_SMB_CTRL) ||
                   (ra == SRAC_ADDR_PRIMARY) || (ra == SRAC_ADDR_SECOND) || (ra == SRAC_ADDR_LOW_TIMEOUT) ||
                   (ra == SRAC_ADDR_OWN_CTRL) || (ra == SRAC_ADDR_IRQ_STATUS) ||
                   (ra == SRAC_ADDR_IRQ_MASK) || (ra == SRAC_ADDR_MATCH_STATUS);
  wire [31:0] rd_mux =
    (ra == SRAC_ADDR_RANGE_UPPER) ? {24'h00_0000, range_slave_address, 1'b0} :
    (ra == SRAC_ADDR_SMB_CTRL) ? {24'h00_0000, smbus_control_status} :
    (ra == SRAC_ADDR_PRIMARY) ? {24'h00_0000, primary_address, 1'b0} :
    (ra == SRAC_ADDR_SECOND) ? {24'h00_0000, second_address, 1'b0} :
    (ra == SRAC_ADDR_LOW_TIMEOUT) ? {16'h0000, low_timeout_value} :
    (ra == SRAC_ADDR_OWN_CTRL) ? {30'h0000_0000, range_match_mode, transmit_ack_value} :
    (ra == SRAC_ADDR_IRQ_STATUS) ? {27'h000_0000, irq_status} :
    (ra == SRAC_ADDR_IRQ_MASK) ? {27'h000_0000, irq_mask} :
    (ra == SRAC_ADDR_MATCH_STATUS) ? {16'h0000, ack_state, 2'b00, match_kind, 1'b0, last_match_address} :
    32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_mapped ? AXI_RESP_OKAY : AXI_RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // srac_range_smbus

// file: srac_bus_model.sv
// Two-wire bus master model feeding addresses, received bytes and line levels.
`timescale 1ns/1ps
module srac_bus_model (
  input wire logic aclk,
  output logic scl_in,
  output logic sda_in,
  output logic [6:0] rx_address,
  output logic rx_address_valid,
  output logic rx_byte_done
);
  initial begin
    scl_in = 1'b1;
    sda_in = 1'b1;
    rx_address = 7'h55;
    rx_address_valid = 1'b0;
    rx_byte_done = 1'b0;
  end
  // After its pulse the address shows its inverse, so a stale value cannot match.
  task automatic send_addr(input logic [6:0] a);
    @(posedge aclk);
    rx_address <= a;
    rx_address_valid <= 1'b1;
    @(posedge aclk);
    rx_address <= ~a;
    rx_address_valid <= 1'b0;
  endtask
  task automatic send_byte();
    @(posedge aclk);
    rx_byte_done <= 1'b1;
    @(posedge aclk);
    rx_byte_done <= 1'b0;
  endtask
  task automatic set_lines(input logic c, input logic d);
    @(posedge aclk);
    scl_in <= c;
    sda_in <= d;
  endtask
endmodule // srac_bus_model

// file: srac_sva.sv
// Concurrent checks on the ports of the SMBus range and control block.
`timescale 1ns/1ps
module srac_sva
  import srac_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_address_valid,
  input wire logic rx_byte_done,
  input wire logic address_match,
  input wire logic ack_valid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_match_cause: assert property (address_match |-> $past(rx_address_valid))
    else $error("address match without a received address");
  chk_ack_cause: assert property (ack_valid |-> $past(rx_byte_done) || $rose(s_axi_bvalid))
    else $error("acknowledge without a byte or a completed write");
  chk_ack_single: assert property (ack_valid |=> !ack_valid)
    else $error("acknowledge pulse longer than one cycle");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
endmodule // srac_sva
bind srac_range_smbus srac_sva u_sva (.*);

// file: tb_top.sv
// Self-checking bench of the SMBus range and control block.
`timescale 1ns/1ps
module tb_top
  import srac_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [SRAC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic scl_in, sda_in, rx_address_valid, rx_byte_done, address_match, ack_valid, ack_nack, irq;
  logic [6:0] rx_address;
  logic [3:0] match_kind;
  logic hit = 0, ack_seen = 0, ack_val = 0;
  int miscompares = 0, compares = 0, cycles = 0;

  srac_range_smbus DUT (.*);
  srac_bus_model u_bus (.*);

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (address_match === 1'b1) hit <= 1'b1;
    if (ack_valid === 1'b1) ack_seen <= 1'b1;
    if (ack_valid === 1'b1) ack_val <= ack_nack;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end

  // ==========================================
  // Bus cycles and comparison
  // ==========================================
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic try_addr(input logic [6:0] a, input logic exp);
    hit = 1'b0;
    u_bus.send_addr(a);
    repeat (2) @(posedge aclk);
    check(32'(hit), 32'(exp), "address match");
  endtask
  task automatic smb_bit(input logic [31:0] m, input logic [31:0] exp, input string what);
    axi_rd(SRAC_ADDR_SMB_CTRL);
    check(rd & m, exp, what);
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_regs();
    smb_bit(32'hFFFF_FFFF, 32'h0000_0000, "control reset");
    axi_wr(SRAC_ADDR_RANGE_UPPER, 32'h0000_00FF);
    axi_rd(SRAC_ADDR_RANGE_UPPER);
    check(rd, 32'h0000_00FE, "range bit zero");
    axi_rd(8'h10);
    check(32'(rr), 32'(AXI_RESP_DECERR), "unmapped read");
    axi_wr(8'h10, 32'h0000_0000);
    check(32'(rr), 32'(AXI_RESP_DECERR), "unmapped write");
    $display("t_regs done");
  endtask
  task automatic t_match();
    try_addr(7'h7F, 1'b1);
    axi_wr(SRAC_ADDR_RANGE_UPPER, 32'h0000_0000);
    try_addr(7'h7F, 1'b0);
    axi_wr(SRAC_ADDR_PRIMARY, 32'h0000_0020);
    axi_wr(SRAC_ADDR_RANGE_UPPER, 32'h0000_0040);
    axi_wr(SRAC_ADDR_OWN_CTRL, 32'h0000_0002);
    try_addr(7'h10, 1'b1);
    try_addr(7'h20, 1'b1);
    try_addr(7'h21, 1'b0);
    try_addr(7'h0F, 1'b0);
    try_addr(7'h0C, 1'b0);
    axi_wr(SRAC_ADDR_SECOND, 32'h0000_006E);
    try_addr(7'h37, 1'b0);
    axi_wr(SRAC_ADDR_SMB_CTRL, 32'h0000_0060);
    try_addr(7'h0C, 1'b1);
    try_addr(7'h10, 1'b1);
    try_addr(7'h37, 1'b1);
    check(32'(match_kind), 32'h0000_0008, "match kind second");
    axi_wr(SRAC_ADDR_SMB_CTRL, 32'h0000_0000);
    $display("t_match done");
  endtask
  task automatic t_ack();
    axi_wr(SRAC_ADDR_OWN_CTRL, 32'h0000_0001);
    ack_seen = 1'b0;
    u_bus.send_byte();
    repeat (2) @(posedge aclk);
    check(32'({ack_seen, ack_val}), 32'h0000_0003, "stored nack");
    axi_wr(SRAC_ADDR_IRQ_MASK, 32'h0000_0010);
    axi_wr(SRAC_ADDR_SMB_CTRL, 32'h0000_0080);
    ack_seen = 1'b0;
    u_bus.send_byte();
    repeat (4) @(posedge aclk);
    check(32'({ack_seen, irq}), 32'h0000_0001, "ack request");
    axi_wr(SRAC_ADDR_OWN_CTRL, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    check(32'({ack_seen, ack_val}), 32'h0000_0002, "fast ack");
    axi_wr(SRAC_ADDR_IRQ_MASK, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    check(32'(irq), 32'h0000_0000, "irq masked");
    axi_wr(SRAC_ADDR_IRQ_STATUS, 32'h0000_0010);
    axi_wr(SRAC_ADDR_IRQ_MASK, 32'h0000_0010);
    repeat (3) @(posedge aclk);
    check(32'(irq), 32'h0000_0000, "irq cleared");
    axi_wr(SRAC_ADDR_SMB_CTRL, 32'h0000_0000);
    $display("t_ack done");
  endtask
  task automatic t_timeout();
    axi_wr(SRAC_ADDR_LOW_TIMEOUT, 32'h0000_0200);
    repeat (250) @(posedge aclk);
    smb_bit(32'h0000_0004, 32'h0000_0004, "idle flag");
    axi_wr(SRAC_ADDR_SMB_CTRL, 32'h0000_0004);
    smb_bit(32'h0000_0004, 32'h0000_0004, "idle read only");
    u_bus.set_lines(1'b0, 1'b1);
    repeat (3) @(posedge aclk);
    smb_bit(32'h0000_0004, 32'h0000_0000, "idle self clear");
    u_bus.set_lines(1'b1, 1'b1);
    axi_wr(SRAC_ADDR_LOW_TIMEOUT, 32'h0000_0001);
    u_bus.set_lines(1'b0, 1'b1);
    repeat (40) @(posedge aclk);
    smb_bit(32'h0000_0008, 32'h0000_0000, "divided tick");
    repeat (200) @(posedge aclk);
    smb_bit(32'h0000_0008, 32'h0000_0008, "low flag set");
    u_bus.set_lines(1'b1, 1'b1);
    axi_wr(SRAC_ADDR_SMB_CTRL, 32'h0000_0008);
    smb_bit(32'h0000_0008, 32'h0000_0000, "low flag cleared");
    axi_wr(SRAC_ADDR_SMB_CTRL, 32'h0000_0001);
    u_bus.set_lines(1'b1, 1'b0);
    repeat (200) @(posedge aclk);
    check(32'(irq), 32'h0000_0001, "high low irq");
    smb_bit(32'h0000_0002, 32'h0000_0002, "high low flag");
    u_bus.set_lines(1'b1, 1'b1);
    axi_wr(SRAC_ADDR_LOW_TIMEOUT, 32'h0000_0000);
    axi_wr(SRAC_ADDR_SMB_CTRL, 32'h0000_0010);
    u_bus.set_lines(1'b0, 1'b1);
    repeat (100) @(posedge aclk);
    smb_bit(32'h0000_0008, 32'h0000_0000, "low timeout off");
    $display("t_timeout done");
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_match();
    t_ack();
    t_timeout();
    finish_test();
  end
endmodule // tb_top
